// ===== rtl/backlight_consts.svh
`ifndef BACKLIGHT_CONSTS_SVH
`define BACKLIGHT_CONSTS_SVH

// register offsets
`define FAULT_FLAGS_ADDR      8'h01
`define BRIGHTNESS_LOW_ADDR   8'h03
`define BRIGHTNESS_HIGH_ADDR  8'h04
`define DRIVE_CONFIG_ADDR     8'h10

// fault flag bit positions
`define OPEN_STRING_BIT       7
`define SHORTED_LED_BIT       6
`define BOOST_UNDER_BIT       4
`define BOOST_OVER_BIT        3
`define BOOST_CURRENT_BIT     2
`define OVER_TEMP_BIT         1
`define SUPPLY_LOCKOUT_BIT    0

// drive configuration fields
`define PWM_STANDBY_BIT       7
`define AUTO_STRING_BIT       2
`define SOURCE_SELECT_MSB     1
`define SOURCE_SELECT_LSB     0

// reset values
`define FAULT_FLAGS_RESET     8'h00
`define BRIGHTNESS_LOW_RESET  8'h00
`define BRIGHTNESS_HIGH_RESET 8'h00
`define DRIVE_CONFIG_RESET    8'h07

// timing
`define STANDBY_LOW_MS        52
`define CLK_FREQ_KHZ          200000

`endif

// ===== rtl/backlight_pkg.sv
package backlight_pkg;

  typedef enum logic [1:0] {
    srcPwmOnly,
    srcRegistersOnly,
    srcPwmTimesRegister,
    srcUnshapedPwmTimesRegister
  } brightness_source_type;

  typedef logic [7:0] reg_byte_type;

endpackage : backlight_pkg

// ===== rtl/level_sync.sv
`timescale 1ns/1ps
module level_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // levels
  input  wire logic [WIDTH-1:0] asyncIn,
  output      logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;

  // first stage feeds only the second
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      stage1_q <= '0;
      syncOut  <= '0;
    end
    else
    begin
      stage1_q <= asyncIn;
      syncOut  <= stage1_q;
    end

endmodule : level_sync

// ===== rtl/backlight_fault_brightness_regs.sv
// Operation
// RULE1: open string: low headroom at boost maximum
// RULE2: open turns off; never flagged in auto
// RULE3: shorted LED: fault headroom beside regulated sink
// RULE4: flags sticky until fault register read
// RULE5: boost under-voltage flag from comparator
// RULE6: boost over-voltage flag from comparator
// RULE7: boost over-current flag from detector
// RULE8: thermal shutdown flags and turns off
// RULE9: supply lockout flags and turns off
// RULE10: low register upper nibble gives LSBs
// RULE11: high register gives level bits 11:4
// RULE12: level changes only on high write
// RULE13: lone high write repeats nibble below
// RULE14: prior low write supplies low nibble
// RULE15: standby turns off after 52 ms low
// RULE16: auto mode disables detected open strings
// RULE17: two-bit field selects brightness source
// RULE18: config writable only while backlight off
// RULE19: host preserves reserved bits, ignores reads
// RULE20: read clears only returned flags
`timescale 1ns/1ps
`include "backlight_consts.svh"
module backlight_fault_brightness_regs #(
  parameter int unsigned STANDBY_CYCLES = `STANDBY_LOW_MS * `CLK_FREQ_KHZ
) (
  // core clock and reset
  input  wire logic                                 clk,
  input  wire logic                                 rst,
  // register access from the serial engine, link clock
  input  wire logic                                 linkClk,
  input  wire logic                                 linkValid,
  output      logic                                 linkReady,
  input  wire logic                                 linkWrite,
  input  wire logic [7:0]                           linkAddr,
  input  wire logic [7:0]                           linkWrData,
  output      logic                                 linkDone,
  output      logic [7:0]                           linkRdData,
  // analog comparators, asynchronous
  input  wire logic [5:0]                           headroomBelowLow,
  input  wire logic [5:0]                           headroomBelowMid,
  input  wire logic [5:0]                           headroomAboveFault,
  input  wire logic                                 boostAtCeiling,
  input  wire logic                                 boostUnderVoltage,
  input  wire logic                                 boostOverVoltage,
  input  wire logic                                 boostOverCurrent,
  input  wire logic                                 overTemperature,
  input  wire logic                                 supplyLockout,
  input  wire logic                                 pwmIn,
  // command logic, core clock
  input  wire logic                                 backlightOnCmd,
  input  wire logic [5:0]                           stringEnableField,
  // drive outputs
  output      logic                                 backlightEnable,
  output      logic [5:0]                           stringEnable,
  output      logic [11:0]                          brightnessLevel,
  output      backlight_pkg::brightness_source_type brightnessSource
);
  import backlight_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // link domain: hold one request and toggle it across

  logic       reqTgl_q;
  logic       ackSeen_q;
  logic       ackSync;
  logic       linkWrite_q;
  logic [7:0] linkAddr_q;
  logic [7:0] linkWrData_q;
  logic [7:0] coreRdData_q;
  wire        linkIdle   = (reqTgl_q == ackSeen_q);
  wire        linkAccept = linkValid && linkIdle;
  wire        linkAck    = (ackSync != ackSeen_q);

  assign linkReady = linkIdle;

  always_ff @(posedge linkClk or posedge rst)
    if (rst)
    begin
      reqTgl_q     <= 1'b0;
      ackSeen_q    <= 1'b0;
      linkWrite_q  <= 1'b0;
      linkAddr_q   <= 8'h00;
      linkWrData_q <= 8'h00;
      linkDone     <= 1'b0;
      linkRdData   <= 8'h00;
    end
    else
    begin
      linkDone <= linkAck;
      if (linkAccept)
      begin
        reqTgl_q     <= ~reqTgl_q;
        linkWrite_q  <= linkWrite;
        linkAddr_q   <= linkAddr;
        linkWrData_q <= linkWrData;
      end
      // read data is stable since the core edge that toggled the acknowledge
      if (linkAck)
      begin
        ackSeen_q  <= ackSync;
        linkRdData <= coreRdData_q;
      end
    end

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers

  logic        reqSync;
  logic        ackTgl_q;
  logic [24:0] analogSync;

  level_sync #(.WIDTH(1)) reqSyncInst (
    .clk     (clk),
    .rst     (rst),
    .asyncIn (reqTgl_q),
    .syncOut (reqSync)
  );

  level_sync #(.WIDTH(1)) ackSyncInst (
    .clk     (linkClk),
    .rst     (rst),
    .asyncIn (ackTgl_q),
    .syncOut (ackSync)
  );

  level_sync #(.WIDTH(25)) analogSyncInst (
    .clk     (clk),
    .rst     (rst),
    .asyncIn ({pwmIn, supplyLockout, overTemperature, boostOverCurrent, boostOverVoltage,
               boostUnderVoltage, boostAtCeiling, headroomAboveFault, headroomBelowMid,
               headroomBelowLow}),
    .syncOut (analogSync)
  );

  // bit map: 5:0 low, 11:6 mid, 17:12 fault, 18 up to 24 single levels
  wire [5:0] belowLow   = analogSync[5:0];
  wire [5:0] belowMid   = analogSync[11:6];
  wire [5:0] aboveFault = analogSync[17:12];
  wire       atCeiling  = analogSync[18];
  wire       pwmLevel   = analogSync[24];

  ////////////////////////////////////////////////////////////////////////////
  // core access decode

  logic [7:0] flags_q;
  logic [7:0] config_q;
  logic [3:0] lowNibble_q;
  logic [7:0] highByte_q;
  logic       lowWritten_q;

  wire accessNow  = (reqSync != ackTgl_q);
  wire writeNow   = accessNow && linkWrite_q;
  wire readNow    = accessNow && !linkWrite_q;
  wire faultRead  = readNow && (linkAddr_q == `FAULT_FLAGS_ADDR);
  wire lowWrite   = writeNow && (linkAddr_q == `BRIGHTNESS_LOW_ADDR);
  wire highWrite  = writeNow && (linkAddr_q == `BRIGHTNESS_HIGH_ADDR);
  // config refused while the backlight is commanded on
  wire cfgWrite   = writeNow && (linkAddr_q == `DRIVE_CONFIG_ADDR) && !backlightOnCmd; // RULE18
  wire autoString = config_q[`AUTO_STRING_BIT];
  wire standbyEn  = config_q[`PWM_STANDBY_BIT];

  // reserved bits read as zero; unmapped addresses read zero
  function automatic logic [7:0] readMux(input logic [7:0] addr, input logic [7:0] flags,
                                         input logic [3:0] lowNib, input logic [7:0] high,
                                         input logic [7:0] cfg);
    case (addr)
      `FAULT_FLAGS_ADDR:     readMux = flags;
      `BRIGHTNESS_LOW_ADDR:  readMux = {lowNib, 4'h0};
      `BRIGHTNESS_HIGH_ADDR: readMux = high;
      `DRIVE_CONFIG_ADDR:    readMux = cfg & 8'h87;
      default:               readMux = 8'h00;
    endcase
  endfunction : readMux

  wire [7:0] rdValue = readMux(linkAddr_q, flags_q, lowNibble_q, highByte_q, config_q); // RULE19

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      ackTgl_q     <= 1'b0;
      coreRdData_q <= 8'h00;
    end
    else if (accessNow)
    begin
      ackTgl_q     <= reqSync;
      coreRdData_q <= rdValue;
    end

  ////////////////////////////////////////////////////////////////////////////
  // fault detection

  // a shorted string shows high headroom while another sink regulates
  function automatic logic shortSeen(input logic [5:0] high, input logic [5:0] low,
                                     input logic [5:0] mid);
    logic [5:0] regulating;
    regulating = ~low & mid;
    shortSeen  = 1'b0;
    for (int i = 0; i < 6; i++)
      if (high[i] && ((regulating & ~(6'h01 << i)) != 6'h00))
        shortSeen = 1'b1;
  endfunction : shortSeen

  wire [5:0] sinkOpen = belowLow & {6{atCeiling}}; // RULE1

  logic [7:0] faultEvents;
  always_comb
  begin
    faultEvents                      = 8'h00;
    faultEvents[`OPEN_STRING_BIT]    = (|sinkOpen) && !autoString; // RULE1 RULE2
    faultEvents[`SHORTED_LED_BIT]    = shortSeen(aboveFault, belowLow, belowMid); // RULE3
    faultEvents[`BOOST_UNDER_BIT]    = analogSync[19]; // RULE5
    faultEvents[`BOOST_OVER_BIT]     = analogSync[20]; // RULE6
    faultEvents[`BOOST_CURRENT_BIT]  = analogSync[21]; // RULE7
    faultEvents[`OVER_TEMP_BIT]      = analogSync[22]; // RULE8
    faultEvents[`SUPPLY_LOCKOUT_BIT] = analogSync[23]; // RULE9
  end

  // clear only what the read returned; a same-cycle event survives
  wire [7:0] flags_d = (faultRead ? 8'h00 : flags_q) | faultEvents; // RULE4 RULE20

  ////////////////////////////////////////////////////////////////////////////
  // shutdown, standby and string handling

  logic        shutdown_q;
  logic [5:0]  openString_q;
  logic [23:0] pwmLowCount_q;

  wire killEvent = faultEvents[`OPEN_STRING_BIT] || faultEvents[`OVER_TEMP_BIT]
                   || faultEvents[`SUPPLY_LOCKOUT_BIT]; // RULE2 RULE8 RULE9
  // shutdown holds until the on command drops; new kills win
  wire shutdown_d = (shutdown_q && backlightOnCmd) || killEvent;
  wire [5:0] openString_d = (backlightOnCmd ? openString_q : 6'h00)
                            | (autoString ? sinkOpen : 6'h00); // RULE16
  wire standbyDone = (pwmLowCount_q == 24'(STANDBY_CYCLES));
  wire standbyOff  = standbyEn && standbyDone; // RULE15
  wire [23:0] pwmLowCount_d = (!standbyEn || pwmLevel) ? 24'h000000
                              : (standbyDone ? pwmLowCount_q : pwmLowCount_q + 24'h000001);

  assign backlightEnable = backlightOnCmd && !shutdown_q && !standbyOff; // RULE15
  assign stringEnable    = stringEnableField & ~openString_q; // RULE16
  assign brightnessSource = brightness_source_type'(
    config_q[`SOURCE_SELECT_MSB:`SOURCE_SELECT_LSB]); // RULE17

  ////////////////////////////////////////////////////////////////////////////
  // register state

  // level takes the repeated nibble unless a low write came first
  wire [3:0] levelLow = lowWritten_q ? lowNibble_q : linkWrData_q[7:4]; // RULE13 RULE14

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      flags_q       <= `FAULT_FLAGS_RESET;
      config_q      <= `DRIVE_CONFIG_RESET;
      lowNibble_q   <= 4'h0;
      highByte_q    <= `BRIGHTNESS_HIGH_RESET;
      lowWritten_q  <= 1'b0;
      brightnessLevel <= 12'h000;
      shutdown_q    <= 1'b0;
      openString_q  <= 6'h00;
      pwmLowCount_q <= 24'h000000;
    end
    else
    begin
      flags_q       <= flags_d; // RULE4
      shutdown_q    <= shutdown_d;
      openString_q  <= openString_d;
      pwmLowCount_q <= pwmLowCount_d;
      if (cfgWrite)
        config_q <= linkWrData_q & 8'h87;
      if (lowWrite)
      begin
        lowNibble_q  <= linkWrData_q[7:4]; // RULE10 RULE14
        lowWritten_q <= 1'b1;
      end
      if (highWrite)
      begin
        highByte_q      <= linkWrData_q;
        lowWritten_q    <= 1'b0;
        brightnessLevel <= {linkWrData_q, levelLow}; // RULE11 RULE12
      end
    end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  flagsSticky_a: assert property (@(posedge clk) disable iff (rst) // RULE4
    !faultRead |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
    else $error("fault flag dropped without a read");

  readClears_a: assert property (@(posedge clk) disable iff (rst) // RULE20
    faultRead |=> (flags_q == $past(faultEvents)))
    else $error("fault read did not clear returned flags only");

  openInAuto_a: assert property (@(posedge clk) disable iff (rst) // RULE2
    (autoString && !flags_q[`OPEN_STRING_BIT] && !faultRead) |=> !flags_q[`OPEN_STRING_BIT])
    else $error("open flag set in automatic mode");

  thermalOff_a: assert property (@(posedge clk) disable iff (rst) // RULE8
    faultEvents[`OVER_TEMP_BIT] |=> (flags_q[`OVER_TEMP_BIT] && !backlightEnable))
    else $error("thermal event did not flag and turn off");

  lockoutOff_a: assert property (@(posedge clk) disable iff (rst) // RULE9
    faultEvents[`SUPPLY_LOCKOUT_BIT] |=> (flags_q[`SUPPLY_LOCKOUT_BIT] && !backlightEnable))
    else $error("lockout event did not flag and turn off");

  levelHeld_a: assert property (@(posedge clk) disable iff (rst) // RULE12
    !highWrite |=> $stable(brightnessLevel))
    else $error("level moved without a high write");

  levelSynth_a: assert property (@(posedge clk) disable iff (rst) // RULE13
    (highWrite && !lowWritten_q) |=> (brightnessLevel == {$past(linkWrData_q), $past(linkWrData_q[7:4])}))
    else $error("synthesized low bits wrong");

  levelLow_a: assert property (@(posedge clk) disable iff (rst) // RULE14
    (highWrite && lowWritten_q) |=> (brightnessLevel == {$past(linkWrData_q), $past(lowNibble_q)}))
    else $error("low register nibble not used");

  configLock_a: assert property (@(posedge clk) disable iff (rst) // RULE18
    (backlightOnCmd && writeNow) |=> $stable(config_q))
    else $error("config written while backlight on");

  standbyOff_a: assert property (@(posedge clk) disable iff (rst) // RULE15
    (standbyEn && pwmLevel) |-> ##1 (!standbyDone || !$past(pwmLevel) || !$past(standbyEn) || STANDBY_CYCLES == 0))
    else $error("standby timer not restarted by pwm high");

  openOff_a: assert property (@(posedge clk) disable iff (rst) // RULE2
    faultEvents[`OPEN_STRING_BIT] |=> (flags_q[`OPEN_STRING_BIT] && !backlightEnable))
    else $error("open event did not flag and turn off");

  standbyCut_a: assert property (@(posedge clk) disable iff (rst) // RULE15
    (standbyEn && !pwmLevel && standbyDone) |-> !backlightEnable)
    else $error("standby timeout left backlight on");

  autoStrings_a: assert property (@(posedge clk) disable iff (rst) // RULE16
    (autoString && backlightOnCmd && (|sinkOpen)) |=> ((stringEnable & $past(sinkOpen)) == 6'h00))
    else $error("open string not disabled in automatic mode");

endmodule : backlight_fault_brightness_regs

// ===== testbench/link_host.sv
`timescale 1ns/1ps
module link_host (
  // answer from the register port
  input  wire logic       linkClk,
  input  wire logic       linkReady,
  input  wire logic       linkDone,
  input  wire logic [7:0] linkRdData,
  // request to the register port
  output      logic       linkValid,
  output      logic       linkWrite,
  output      logic [7:0] linkAddr,
  output      logic [7:0] linkWrData
);
  initial
  begin
    linkValid  = 1'b0;
    linkWrite  = 1'b0;
    linkAddr   = 8'h00;
    linkWrData = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // callers hand over whole bytes, reserved bits as given; the low register write 8'h95 sets two of them
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data,
                        output logic [7:0] rd, output logic ok);
    int n;
    @(posedge linkClk);
    #1;
    for (n = 0; n < 50 && linkReady !== 1'b1; n++)
    begin
      @(posedge linkClk);
      #1;
    end
    linkValid  = 1'b1;
    linkWrite  = wr;
    linkAddr   = addr;
    linkWrData = data;
    @(posedge linkClk);
    #1;
    linkValid  = 1'b0;
    // a stale bus would hide a late sample, so show the inverse
    linkWrite  = ~wr;
    linkAddr   = ~addr;
    linkWrData = ~data;
    for (n = 0; n < 50 && linkDone !== 1'b1; n++)
    begin
      @(posedge linkClk);
      #1;
    end
    rd = linkRdData;
    ok = (linkDone === 1'b1);
  endtask : access
endmodule : link_host

// ===== testbench/backlight_fault_brightness_regs_bench.sv
`timescale 1ns/1ps
module backlight_fault_brightness_regs_bench;
  import backlight_pkg::*;
  localparam int STBY = 20;
  localparam logic [7:0]  MASK [7] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h40, 8'h80};
  localparam logic [7:0]  LO   [2] = '{8'h95, 8'h10};
  localparam logic [7:0]  HI   [6] = '{8'hfc, 8'hdc, 8'h8c, 8'h0c, 8'h00, 8'hff};
  localparam logic [11:0] BR   [6] = '{12'hfc9, 12'hdc1, 12'h8c8, 12'h0c0, 12'h000, 12'hfff};
  logic                  clk = 1'b0;
  logic                  linkClk = 1'b0;
  logic                  rst = 1'b1;
  logic                  linkValid, linkReady, linkWrite, linkDone, ok;
  logic [7:0]            linkAddr, linkWrData, linkRdData, rd;
  logic [5:0]            belowLow = 6'h00, belowMid = 6'h00, aboveFault = 6'h00, enField = 6'h3f, strEn;
  logic                  atCeil = 1'b0, underV = 1'b0, overV = 1'b0, overI = 1'b0, overT = 1'b0;
  logic                  lockout = 1'b0, pwmIn = 1'b1, onCmd = 1'b0, blEnable;
  logic [11:0]           level, lastLvl = 12'h000;
  brightness_source_type source;
  int                    err_total = 0;
  int                    n_tests = 0;

  always #2.5 clk = ~clk;
  initial #1.3 forever #7.5 linkClk = ~linkClk;

  backlight_fault_brightness_regs #(.STANDBY_CYCLES(STBY)) backlight_fault_brightness_regs_inst (
    .clk(clk), .rst(rst), .linkClk(linkClk), .linkValid(linkValid), .linkReady(linkReady),
    .linkWrite(linkWrite), .linkAddr(linkAddr), .linkWrData(linkWrData), .linkDone(linkDone),
    .linkRdData(linkRdData), .headroomBelowLow(belowLow), .headroomBelowMid(belowMid),
    .headroomAboveFault(aboveFault), .boostAtCeiling(atCeil), .boostUnderVoltage(underV),
    .boostOverVoltage(overV), .boostOverCurrent(overI), .overTemperature(overT),
    .supplyLockout(lockout), .pwmIn(pwmIn), .backlightOnCmd(onCmd), .stringEnableField(enField),
    .backlightEnable(blEnable), .stringEnable(strEn), .brightnessLevel(level),
    .brightnessSource(source));

  link_host link_host_inst (
    .linkClk(linkClk), .linkReady(linkReady), .linkDone(linkDone), .linkRdData(linkRdData),
    .linkValid(linkValid), .linkWrite(linkWrite), .linkAddr(linkAddr), .linkWrData(linkWrData));

  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("mismatches %0d of %0d checks", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : chk

  task automatic acc(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    link_host_inst.access(wr, addr, data, rd, ok);
    if (!ok)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      err_total++;
      results();
    end
  endtask : acc

  task automatic rdc(input logic [7:0] addr, input logic [7:0] exp);
    acc(1'b0, addr, 8'h00);
    chk({4'h0, rd}, {4'h0, exp});
  endtask : rdc

  // inputs move one ns after a core edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic fault(input int i, input logic v);
    case (i)
      0: underV = v;
      1: overV = v;
      2: overI = v;
      3: overT = v;
      4: lockout = v;
      5:
      begin
        aboveFault = v ? 6'h01 : 6'h00;
        belowMid   = v ? 6'h02 : 6'h00;
      end
      default:
      begin
        atCeil   = v;
        belowLow = v ? 6'h01 : 6'h00;
      end
    endcase
  endtask : fault

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(20);
    rst = 1'b0;
    cyc(2);
    rdc(8'h01, 8'h00);
    rdc(8'h03, 8'h00);
    rdc(8'h04, 8'h00);
    rdc(8'h10, 8'h07);
    rdc(8'h02, 8'h00);
    chk({10'h000, source}, 12'h003);
    for (int m = 0; m < 4; m++)
    begin
      acc(1'b1, 8'h10, 8'h84 | 8'(m));
      rdc(8'h10, 8'h84 | 8'(m));
      chk({10'h000, source}, 12'(m));
    end
    acc(1'b1, 8'h10, 8'h03);
    rdc(8'h10, 8'h03);
    acc(1'b1, 8'h10, 8'h00);
    cyc(1);
    onCmd = 1'b1;
    // locked while the backlight is on
    acc(1'b1, 8'h10, 8'h07);
    rdc(8'h10, 8'h00);
    for (int i = 0; i < 7; i++)
    begin
      chk(blEnable, 1'b1);
      fault(i, 1'b1);
      cyc(5);
      fault(i, 1'b0);
      cyc(2);
      chk(blEnable, (i == 3 || i == 4 || i == 6) ? 1'b0 : 1'b1);
      rdc(8'h01, MASK[i]);
      rdc(8'h01, 8'h00);
      cyc(1);
      onCmd = 1'b0;
      cyc(3);
      onCmd = 1'b1;
      cyc(3);
    end
    onCmd = 1'b0;
    acc(1'b1, 8'h10, 8'h04);
    cyc(1);
    onCmd = 1'b1;
    pwmIn = 1'b0;
    fault(6, 1'b1);
    cyc(5);
    fault(6, 1'b0);
    cyc(40);
    chk(strEn, 6'h3e);
    chk(blEnable, 1'b1);
    rdc(8'h01, 8'h00);
    cyc(1);
    onCmd = 1'b0;
    pwmIn = 1'b1;
    acc(1'b1, 8'h10, 8'h80);
    cyc(1);
    onCmd = 1'b1;
    cyc(3);
    chk(strEn, 6'h3f);
    pwmIn = 1'b0;
    cyc(STBY / 2);
    chk(blEnable, 1'b1);
    cyc(STBY + 10);
    chk(blEnable, 1'b0);
    pwmIn = 1'b1;
    cyc(6);
    chk(blEnable, 1'b1);
    for (int r = 0; r < 6; r++)
    begin
      if (r < 2)
      begin
        acc(1'b1, 8'h03, LO[r]);
        chk(level, lastLvl);
        rdc(8'h03, LO[r] & 8'hf0);
      end
      acc(1'b1, 8'h04, HI[r]);
      chk(level, BR[r]);
      rdc(8'h04, HI[r]);
      lastLvl = BR[r];
    end
    results();
  end
endmodule : backlight_fault_brightness_regs_bench
